/* File: verilog/isqwt_params.svh */
// Constants for the interval and square-wave timer
// Behaviour
// - Reset loads port-0 direction with all ones
// - Direction 0 drives pin, 1 floats it
// - Drive mode 0 push-pull, 1 open-drain
// - Mode bits 11 start counting on ticks
// - Compare match clears counter, raises first irq
// - Match period is compare value plus one
// - Second compare match still raises second irq
// - Mode bits 00 stop and clear counter
// - Square wave: each first compare match inverts output
// - Counter readable at any time
// - Prescaler low bits select count clock
// - Output disabled holds low; inversion toggles
`ifndef ISQWT_PARAMS_SVH
`define ISQWT_PARAMS_SVH
`define ISQWT_ADDR_LATCH 16'hFF00
`define ISQWT_ADDR_CNT_LO 16'hFF10
`define ISQWT_ADDR_CNT_HI 16'hFF11
`define ISQWT_ADDR_CR0_LO 16'hFF12
`define ISQWT_ADDR_CR0_HI 16'hFF13
`define ISQWT_ADDR_CR1_LO 16'hFF14
`define ISQWT_ADDR_CR1_HI 16'hFF15
`define ISQWT_ADDR_DIR 16'hFF20
`define ISQWT_ADDR_DRIVE 16'hFF38
`define ISQWT_ADDR_MODE 16'hFFBA
`define ISQWT_ADDR_PRESC 16'hFFBB
`define ISQWT_ADDR_OUTC 16'hFFBD
`define ISQWT_RST_DIR 8'hFF
`define ISQWT_RST_DRIVE 8'h00
`define ISQWT_RST_BYTE 8'h00
`define ISQWT_RST_WORD 16'h0000
`define ISQWT_MODE_LSB 2
`define ISQWT_MODE_RUN 2'h3
`define ISQWT_MODE_STOP 2'h0
`define ISQWT_OUTC_TOE 0
`define ISQWT_OUTC_INV 1
`define ISQWT_OUTC_LVR 2
`define ISQWT_OUTC_LVS 3
`define ISQWT_OUTC_RDMASK 8'hF3
`define ISQWT_ES_LSB 4
`define ISQWT_ES_FALL 2'h0
`define ISQWT_ES_RISE 2'h1
`define ISQWT_ES_BOTH 2'h3
`define ISQWT_DIV_A 4
`define ISQWT_DIV_B 256
`define ISQWT_PIN_IN 2
`define ISQWT_PIN_OUT 3
`define ISQWT_PIN_PCH 7
`endif

/* File: verilog/isqwt_pkg.sv */
// Types for the interval and square-wave timer
package isqwt_pkg;
	typedef enum logic [1:0]
	{
		ISQWT_ST_STOP = 2'h1,
		ISQWT_ST_RUN = 2'h2
	} isqwt_state_e;

	typedef enum logic [1:0]
	{
		ISQWT_CK_SYS = 2'h0,
		ISQWT_CK_DIVA = 2'h1,
		ISQWT_CK_DIVB = 2'h2,
		ISQWT_CK_EXT = 2'h3
	} isqwt_ck_e;

	typedef struct packed
	{
		isqwt_state_e st;
		logic [7:0] mode;
		logic [7:0] presc;
		logic [7:0] outc;
		logic [15:0] cr0;
		logic [15:0] cr1;
		logic [15:0] cnt;
		logic [7:0] dir;
		logic [7:0] drive;
		logic [7:0] latch;
		logic tout;
		logic irq1;
		logic irq2;
		logic [7:0] rdata;
	} isqwt_top_s;

	typedef struct packed
	{
		logic sync1;
		logic sync2;
		logic hist;
		logic filt;
		logic [7:0] div;
	} isqwt_ck_s;
endpackage

/* File: verilog/isqwt_tick_if.sv */
// Count clock request and tick between timer core and clock generator
`timescale 1ns/10ps
`default_nettype none
interface isqwt_tick_if;
	logic run;
	logic [1:0] ck_sel;
	logic [1:0] es;
	logic tick;
	modport gen (input run, input ck_sel, input es, output tick);
	modport core (output run, output ck_sel, output es, input tick);
endinterface
`default_nettype wire

/* File: verilog/isqwt_clkgen.sv */
// Count clock generator: prescaler and filtered external edge
`timescale 1ns/10ps
`default_nettype none
`include "isqwt_params.svh"
module isqwt_clkgen #(
	parameter int DIV_A = `ISQWT_DIV_A,
	parameter int DIV_B = `ISQWT_DIV_B
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic ext_pin_i,
	isqwt_tick_if.gen tick_if
);
	localparam logic [7:0] MASK_A = 8'(DIV_A - 1);
	localparam logic [7:0] MASK_B = 8'(DIV_B - 1);

	generate
		if (DIV_A < 2 || DIV_A > 256 || (DIV_A & (DIV_A - 1)) != 0)
		begin : g_bad_a
			$error("DIV_A must be a power of two from 2 to 256");
		end
		if (DIV_B < 2 || DIV_B > 256 || (DIV_B & (DIV_B - 1)) != 0)
		begin : g_bad_b
			$error("DIV_B must be a power of two from 2 to 256");
		end
	endgenerate

	isqwt_pkg::isqwt_ck_s q;
	isqwt_pkg::isqwt_ck_s d;
	logic stable;
	logic chg;
	logic edge_hit;

	// A level counts only once seen on two samples in a row
	assign stable = (q.sync2 == q.hist);
	assign chg = stable && (q.sync2 != q.filt);

	always_comb
	begin
		edge_hit = 1'b0;
		case (tick_if.es)
			`ISQWT_ES_FALL: edge_hit = chg && !q.sync2;
			`ISQWT_ES_RISE: edge_hit = chg && q.sync2;
			`ISQWT_ES_BOTH: edge_hit = chg;
			default: edge_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		tick_if.tick = 1'b0;
		case (isqwt_pkg::isqwt_ck_e'(tick_if.ck_sel))
			isqwt_pkg::ISQWT_CK_SYS: tick_if.tick = tick_if.run;
			isqwt_pkg::ISQWT_CK_DIVA: tick_if.tick = tick_if.run && ((q.div & MASK_A) == MASK_A);
			isqwt_pkg::ISQWT_CK_DIVB: tick_if.tick = tick_if.run && ((q.div & MASK_B) == MASK_B);
			isqwt_pkg::ISQWT_CK_EXT: tick_if.tick = tick_if.run && edge_hit;
			default: tick_if.tick = 1'b0;
		endcase
	end

	always_comb
	begin
		d = q;
		d.sync1 = ext_pin_i;
		d.sync2 = q.sync1;
		d.hist = q.sync2;
		if (stable)
		begin
			d.filt = q.sync2;
		end
		// Prescaler restarts on every start so the first tick is aligned
		d.div = tick_if.run ? q.div + 8'h01 : 8'h00;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	a_tick_needs_run: assert property (!tick_if.run |-> !tick_if.tick)
		else $error("count tick while stopped");
	a_diva_spacing: assert property (
		(tick_if.run && tick_if.ck_sel == 2'h1 && tick_if.tick) ##1
		(tick_if.run && tick_if.ck_sel == 2'h1) [*3] |-> !$past(tick_if.tick))
		else $error("divided tick repeats too soon");
endmodule
`default_nettype wire

/* File: verilog/isqwt_timer.sv */
// Interval and square-wave timer with port-0 pin control
`timescale 1ns/10ps
`default_nettype none
`include "isqwt_params.svh"
module isqwt_timer (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [15:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [7:0] port0_pad_i,
	output logic [7:0] port0_pad_o,
	output logic [7:0] port0_pad_oe_o,
	output logic first_match_irq_o,
	output logic second_match_irq_o,
	output logic timer_output_pin_o
);
	isqwt_pkg::isqwt_top_s q;
	isqwt_pkg::isqwt_top_s d;
	isqwt_tick_if tick_if ();
	logic tick;
	logic running;
	logic mode_wr;
	logic outc_wr;
	logic [1:0] next_op;
	logic [7:0] pin_val;

	// Read mux; low and high counter bytes are separate reads and may tear
	function automatic logic [7:0] sfr_read(
		input logic [15:0] a,
		input isqwt_pkg::isqwt_top_s s
	);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`ISQWT_ADDR_LATCH: r = s.latch;
			`ISQWT_ADDR_CNT_LO: r = s.cnt[7:0];
			`ISQWT_ADDR_CNT_HI: r = s.cnt[15:8];
			`ISQWT_ADDR_CR0_LO: r = s.cr0[7:0];
			`ISQWT_ADDR_CR0_HI: r = s.cr0[15:8];
			`ISQWT_ADDR_CR1_LO: r = s.cr1[7:0];
			`ISQWT_ADDR_CR1_HI: r = s.cr1[15:8];
			`ISQWT_ADDR_DIR: r = s.dir;
			`ISQWT_ADDR_DRIVE: r = s.drive;
			`ISQWT_ADDR_MODE: r = s.mode;
			`ISQWT_ADDR_PRESC: r = s.presc;
			`ISQWT_ADDR_OUTC: r = s.outc & `ISQWT_OUTC_RDMASK;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	isqwt_clkgen u_clkgen (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.ext_pin_i(port0_pad_i[`ISQWT_PIN_IN]),
		.tick_if(tick_if)
	);

	assign running = (q.st == isqwt_pkg::ISQWT_ST_RUN);
	assign tick_if.run = running;
	assign tick_if.ck_sel = q.presc[1:0];
	assign tick_if.es = q.presc[`ISQWT_ES_LSB +: 2];
	assign tick = tick_if.tick;
	assign mode_wr = sfr_wr_i && (sfr_addr_i == `ISQWT_ADDR_MODE);
	assign outc_wr = sfr_wr_i && (sfr_addr_i == `ISQWT_ADDR_OUTC);

	always_comb
	begin
		d = q;
		next_op = 2'h0;
		d.irq1 = 1'b0;
		d.irq2 = 1'b0;
		// Counting step, only while running
		if (running && tick)
		begin
			if (q.cnt == q.cr0)
			begin
				d.cnt = 16'h0000;
				d.irq1 = 1'b1;
				if (q.outc[`ISQWT_OUTC_INV])
				begin
					d.tout = !q.tout;
				end
			end
			else
			begin
				d.cnt = q.cnt + 16'h0001;
			end
			if (q.cnt == q.cr1)
			begin
				d.irq2 = 1'b1;
			end
		end
		if (sfr_wr_i)
		begin
			case (sfr_addr_i)
				`ISQWT_ADDR_LATCH: d.latch = sfr_wdata_i;
				`ISQWT_ADDR_CR0_LO: d.cr0[7:0] = sfr_wdata_i;
				`ISQWT_ADDR_CR0_HI: d.cr0[15:8] = sfr_wdata_i;
				`ISQWT_ADDR_CR1_LO: d.cr1[7:0] = sfr_wdata_i;
				`ISQWT_ADDR_CR1_HI: d.cr1[15:8] = sfr_wdata_i;
				`ISQWT_ADDR_DIR: d.dir = sfr_wdata_i;
				`ISQWT_ADDR_DRIVE: d.drive = sfr_wdata_i;
				`ISQWT_ADDR_MODE: d.mode = sfr_wdata_i;
				`ISQWT_ADDR_PRESC: d.presc = sfr_wdata_i;
				`ISQWT_ADDR_OUTC:
				begin
					d.outc = sfr_wdata_i & `ISQWT_OUTC_RDMASK;
					// Level triggers act once and are never stored
					if (sfr_wdata_i[`ISQWT_OUTC_LVS])
					begin
						d.tout = 1'b1;
					end
					else if (sfr_wdata_i[`ISQWT_OUTC_LVR])
					begin
						d.tout = 1'b0;
					end
				end
				default: d.latch = d.latch;
			endcase
		end
		if (!d.outc[`ISQWT_OUTC_TOE])
		begin
			d.tout = 1'b0;
		end
		next_op = d.mode[`ISQWT_MODE_LSB +: 2];
		// Modes other than 11 are treated as stopped
		if (next_op == `ISQWT_MODE_RUN)
		begin
			d.st = isqwt_pkg::ISQWT_ST_RUN;
		end
		else
		begin
			d.st = isqwt_pkg::ISQWT_ST_STOP;
			d.cnt = 16'h0000;
			// A stop write clears a same-cycle match's irqs but not its output inversion
			d.irq1 = 1'b0;
			d.irq2 = 1'b0;
		end
		if (sfr_rd_i)
		begin
			d.rdata = sfr_read(sfr_addr_i, q);
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			q.st <= isqwt_pkg::ISQWT_ST_STOP;
			q.mode <= `ISQWT_RST_BYTE;
			q.presc <= `ISQWT_RST_BYTE;
			q.outc <= `ISQWT_RST_BYTE;
			q.cr0 <= `ISQWT_RST_WORD;
			q.cr1 <= `ISQWT_RST_WORD;
			q.cnt <= `ISQWT_RST_WORD;
			q.dir <= `ISQWT_RST_DIR;
			q.drive <= `ISQWT_RST_DRIVE;
			q.latch <= `ISQWT_RST_BYTE;
			q.tout <= 1'b0;
			q.irq1 <= 1'b0;
			q.irq2 <= 1'b0;
			q.rdata <= `ISQWT_RST_BYTE;
		end
		else
		begin
			q <= d;
		end
	end

	// Pad drivers; timer output is merged into the shared pin
	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_pad
			if (i == `ISQWT_PIN_OUT)
			begin : g_shared
				assign pin_val[i] = q.latch[i] | q.tout;
			end
			else
			begin : g_plain
				assign pin_val[i] = q.latch[i];
			end
			if (i == `ISQWT_PIN_PCH)
			begin : g_pch
				assign port0_pad_oe_o[i] = !q.dir[i] && (!q.drive[i] || pin_val[i]);
			end
			else
			begin : g_nch
				assign port0_pad_oe_o[i] = !q.dir[i] && (!q.drive[i] || !pin_val[i]);
			end
		end
	endgenerate

	assign port0_pad_o = pin_val;
	assign sfr_rdata_o = q.rdata;
	assign first_match_irq_o = q.irq1;
	assign second_match_irq_o = q.irq2;
	assign timer_output_pin_o = q.tout;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_match;
		running && tick && (q.cnt == q.cr0) && !mode_wr;
	endsequence

	sequence s_step;
		running && tick && (q.cnt != q.cr0) && !mode_wr;
	endsequence

	a_match_clears: assert property (s_match |=> (q.cnt == 16'h0000) && q.irq1)
		else $error("match did not clear counter and raise irq");
	a_step_increments: assert property (s_step |=> q.cnt == $past(q.cnt) + 16'h0001)
		else $error("counter did not advance by one");
	a_idle_holds: assert property (running && !tick && !mode_wr |=> $stable(q.cnt))
		else $error("counter moved without a tick");
	a_second_match: assert property (running && tick && q.cnt == q.cr1 && !mode_wr |=> q.irq2)
		else $error("second match irq missing");
	a_square_toggle: assert property (
		s_match ##0 (q.outc[`ISQWT_OUTC_TOE] && q.outc[`ISQWT_OUTC_INV] && !outc_wr)
		|=> q.tout != $past(q.tout))
		else $error("match did not invert timer output");
	a_output_low: assert property (!q.outc[`ISQWT_OUTC_TOE] |-> !timer_output_pin_o)
		else $error("disabled timer output not low");
	a_stop_zero: assert property (!running |-> q.cnt == 16'h0000 && !first_match_irq_o)
		else $error("stopped timer not held at zero");
	a_stop_cmd: assert property (mode_wr && sfr_wdata_i[3:2] == 2'h0 |=> !running ##1 !q.irq1)
		else $error("stop command not obeyed");
	a_start_cmd: assert property (mode_wr && sfr_wdata_i[3:2] == 2'h3 |=> running)
		else $error("start command not obeyed");
	a_dir_reset: assert property ($fell(reset_i) |-> q.dir == 8'hFF)
		else $error("direction not all ones after reset");
	a_input_float: assert property ((port0_pad_oe_o & q.dir) == 8'h00)
		else $error("input-mode pin is driven");
	a_open_drain: assert property ((port0_pad_oe_o & q.drive & port0_pad_o & 8'h7F) == 8'h00)
		else $error("n-channel open drain drove high");
	a_stop_no_irq2: assert property (!running |-> !second_match_irq_o)
		else $error("second match irq while stopped");
	a_irq1_cause: assert property (!(running && tick && q.cnt == q.cr0) |=> !q.irq1)
		else $error("first match irq without a match");
	// Output moves only on a match or an output control write
	a_tout_cause: assert property (
		!(running && tick && q.cnt == q.cr0) && !outc_wr |=> $stable(q.tout))
		else $error("timer output changed without cause");
	a_read_holds: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
		else $error("read data changed without a read");
	a_read_count: assert property (
		sfr_rd_i && sfr_addr_i == `ISQWT_ADDR_CNT_LO |=> sfr_rdata_o == $past(q.cnt[7:0]))
		else $error("counter read returned wrong value");
endmodule
`default_nettype wire

/* File: verif/isqwt_timer_tb_top.sv */
// Self-checking bench for the interval and square-wave timer
`timescale 1ns/10ps
`default_nettype none
`include "isqwt_params.svh"
module isqwt_timer_tb_top;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] pad_in = 8'h00;
	logic [1:0] ext_cnt = 2'h0;
	logic [7:0] rdata, pad_o, pad_oe;
	logic irq1, irq2, tout;
	logic [31:0] seed = 32'h4345;
	logic [7:0] psel [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h13, 8'h33};
	int pmul [6] = '{1, 4, 256, 8, 8, 4};
	int err_total = 0;
	int total_checks = 0;

	always #50 sys_clk_i = ~sys_clk_i;

	isqwt_timer dut_u (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.sfr_addr_i(addr),
		.sfr_wdata_i(wdata),
		.sfr_wr_i(wr),
		.sfr_rd_i(rd),
		.sfr_rdata_o(rdata),
		.port0_pad_i(pad_in),
		.port0_pad_o(pad_o),
		.port0_pad_oe_o(pad_oe),
		.first_match_irq_o(irq1),
		.second_match_irq_o(irq2),
		.timer_output_pin_o(tout)
	);

	// Four cycles per level keeps each pulse well above two clocks
	always @(negedge sys_clk_i)
	begin
		ext_cnt <= ext_cnt + 2'h1;
		if (ext_cnt == 2'h3)
			pad_in[2] <= ~pad_in[2];
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Open drain: bits 0-6 drive only low, bit 7 only high
	function automatic logic [7:0] exp_oe(input logic [7:0] dir, drv, lat);
		return ~dir & ~(drv & {~lat[7], lat[6:0]});
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge sys_clk_i);
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		addr = a;
		rd = 1'b1;
		@(negedge sys_clk_i);
		rd = 1'b0;
		d = rdata;
	endtask

	// Cycles from one match pulse to the next, with output levels at both
	task automatic gap(input bit sec, output int n, output logic t0, output logic t1);
		int i;
		for (i = 0; i < 3000 && (sec ? irq2 : irq1) !== 1'b1; i++)
			@(negedge sys_clk_i);
		t0 = tout;
		n = 1;
		@(negedge sys_clk_i);
		while (n < 3000 && (sec ? irq2 : irq1) !== 1'b1)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		t1 = tout;
		check(pad_o[3], tout);
	endtask

	task automatic run(input logic [7:0] presc, input int mul);
		logic [31:0] r;
		logic [15:0] m;
		logic [7:0] outc, d;
		logic t0, t1;
		int n, k;
		r = xs();
		m = 16'h0002 + {14'h0000, r[1:0]};
		outc = (presc == 8'h00) ? 8'h03 : {6'h00, r[3], r[2] | r[3]};
		wr_reg(`ISQWT_ADDR_MODE, 8'h00);
		wr_reg(`ISQWT_ADDR_PRESC, presc);
		wr_reg(`ISQWT_ADDR_CR0_LO, m[7:0]);
		wr_reg(`ISQWT_ADDR_CR0_HI, m[15:8]);
		wr_reg(`ISQWT_ADDR_CR1_LO, {1'b0, m[7:1]});
		wr_reg(`ISQWT_ADDR_CR1_HI, 8'h00);
		wr_reg(`ISQWT_ADDR_OUTC, outc);
		wr_reg(`ISQWT_ADDR_MODE, 8'h0C);
		gap(1'b0, n, t0, t1);
		gap(1'b0, n, t0, t1);
		check(n, mul * (m + 1));
		check({t0, t1}, outc[0] ? {t0, outc[1] ^ t0} : 2'b00);
		if (presc == 8'h02)
		begin
			// Slow ticks make the count stable long enough to read
			repeat (300) @(negedge sys_clk_i);
			rd_reg(`ISQWT_ADDR_CNT_LO, d);
			check(d, 8'h01);
			rd_reg(`ISQWT_ADDR_CNT_HI, d);
			check(d, 8'h00);
		end
		gap(1'b1, n, t0, t1);
		check(n, mul * (m + 1));
		wr_reg(`ISQWT_ADDR_MODE, 8'h00);
		rd_reg(`ISQWT_ADDR_CNT_LO, d);
		check(d, 8'h00);
		n = 0;
		for (k = 0; k < 600; k++)
		begin
			@(negedge sys_clk_i);
			n += (irq1 !== 1'b0 || irq2 !== 1'b0);
		end
		check(n, 0);
	endtask

	initial
	begin
		logic [7:0] d, dir, drv, lat;
		logic [31:0] r;
		int k;
		repeat (10) @(negedge sys_clk_i);
		reset_i = 1'b0;
		check(pad_oe, 8'h00);
		rd_reg(`ISQWT_ADDR_DIR, d);
		check(d, 8'hFF);
		rd_reg(`ISQWT_ADDR_DRIVE, d);
		check(d, 8'h00);
		rd_reg(16'hFF7F, d);
		check(d, 8'h00);
		for (k = 0; k < 10; k++)
		begin
			r = xs();
			{dir, drv, lat} = (k == 0) ? 24'h00FFFF : r[23:0];
			wr_reg(`ISQWT_ADDR_DIR, dir);
			wr_reg(`ISQWT_ADDR_DRIVE, drv);
			wr_reg(`ISQWT_ADDR_LATCH, lat);
			check(pad_oe, exp_oe(dir, drv, lat));
			check(pad_o & pad_oe, lat & pad_oe);
			rd_reg(`ISQWT_ADDR_DIR, d);
			check(d, dir);
		end
		wr_reg(`ISQWT_ADDR_DIR, 8'hF7);
		wr_reg(`ISQWT_ADDR_DRIVE, 8'h00);
		wr_reg(`ISQWT_ADDR_LATCH, 8'h00);
		// Force bits: high only with enable, and they read back as zero
		wr_reg(`ISQWT_ADDR_OUTC, 8'h08);
		check(tout, 1'b0);
		wr_reg(`ISQWT_ADDR_OUTC, 8'h09);
		check(pad_o[3], 1'b1);
		rd_reg(`ISQWT_ADDR_OUTC, d);
		check(d, 8'h01);
		wr_reg(`ISQWT_ADDR_OUTC, 8'h05);
		check(tout, 1'b0);
		for (k = 0; k < 6; k++)
			run(psel[k], pmul[k]);
		stop_test();
	end

	initial
	begin
		#5000000;
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
